// file: rtl/xt_cfg.svh
`ifndef XT_CFG_SVH
`define XT_CFG_SVH
// ----------------------------------------------------------------
// Telegram constants
// ----------------------------------------------------------------
`define MAX_PZD        16
`define NTAP_DEF       4
`define ENTRY_WORDS    5
`define PRM_BLK_WORD   5'h01
`define PRM_ENT_WORD   5'h02
`define ID_LEN         3'h5
`define EMPTY_ID0      8'h04
`define EMPTY_ID1      8'h00
`define EMPTY_ID2      8'h00
`define EMPTY_ID3      8'hD3
`define EMPTY_ID4      8'h40
`define CW1_SLOT       4'h0
`define PASSIVE_BIT1   4'hF
`define XT_CORR_BIT    4'h0
`define XT_PASSIVE_BIT 4'h1
// ----------------------------------------------------------------
// Controller register map and fields
// ----------------------------------------------------------------
`define A_CTRL         8'h00
`define A_STAT         8'h04
`define A_TXB          8'h40
`define A_RXB          8'h80
`define A_END          8'hC0
`define CTRL_KIND_LSB  0
`define CTRL_LEN_LSB   4
`define CTRL_DST_LSB   16
`define CTRL_GO_BIT    31
`endif

// file: rtl/xt_pkg.sv
package xt_pkg;
   // Telegram kinds sent by the bus master.
   typedef enum logic [1:0] {K_PRM, K_CFG, K_DX, K_DXB} kind_t;
   typedef logic [15:0][15:0] image_t;
endpackage

// file: rtl/xt_if.sv
`timescale 1ns/1ps
interface xt_if;
   import xt_pkg::*;
   // Master telegram words, seen by every node.
   logic        m_valid;
   kind_t       m_kind;
   logic [6:0]  m_dst;
   logic [15:0] m_data;
   logic        m_last;
   // Reply words of the drive.
   logic        r_valid;
   logic        r_bcast;
   logic [15:0] r_data;
   logic        r_last;
   // Broadcast words of peer publishers.
   logic        px_valid;
   logic [6:0]  px_src;
   logic [15:0] px_data;
   logic        px_last;
   modport drive (input m_valid, m_kind, m_dst, m_data, m_last,
                  input px_valid, px_src, px_data, px_last,
                  output r_valid, r_bcast, r_data, r_last);
   modport master (output m_valid, m_kind, m_dst, m_data, m_last,
                   input r_valid, r_bcast, r_data, r_last);
endinterface

// file: rtl/drive_end.sv
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "xt_cfg.svh"
// Notes on behaviour
// - Master polls each slave, delivering setpoints.
// - Polled drive answers with its actual values.
// - Publisher is polled with the broadcast code.
// - Publisher answer is broadcast to all nodes.
// - Subscriber adopts selected publisher words as setpoints.
// - Publisher and master words merged per structure.
// - Several independent taps per publisher link.
// - At most sixteen process data words.
// - Configuration telegram gives setpoint and actual counts.
// - Without cross-traffic, setpoints come from master only.
// - Entry: publisher, length, offset, count, destination.
// - Filter table arrives inside parameter telegram.
// - Missing block or zero links disables subscriber.
// - Empty identifier 04 00 00 D3 40 per access.
// - Cross-traffic needs enabling on both sides.
// - Correction and passive referencing request bits.
// - Correction and passive referencing status bits.
module drive_end
   import xt_pkg::*;
#(
   parameter int NTAP = `NTAP_DEF
)
(
   // Clock and reset.
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   // Fieldbus.
   xt_if.drive               bus,
   // Local configuration.
   input  wire logic [6:0]   node_addr_i,
   input  wire logic         pub_en_i,
   input  wire logic         sub_en_i,
   input  wire logic [15:0]  telegram_structure_config_i,
   input  wire logic [3:0]   xt_ctl_slot_i,
   input  wire logic [3:0]   xt_sts_slot_i,
   // Drive application.
   input  wire logic [255:0] act_i,
   input  wire logic         pos_corr_done_i,
   input  wire logic         passive_ref_done_i,
   output logic [255:0]      setpoint_o,
   output logic              pos_corr_req_o,
   output logic              passive_ref_req_o,
   output logic              sub_active_o,
   output logic              cfg_err_o
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic {D_RX, D_TX} dstate_t;
   typedef struct packed {
      dstate_t                st;
      logic [4:0]             widx;
      logic [4:0]             wptr;
      logic [4:0]             set_words;
      logic [4:0]             act_words;
      logic                   cfg_err;
      logic [2:0]             idb;
      logic [4:0]             ids;
      logic [4:0]             nl;
      logic [4:0]             ent;
      logic [2:0]             fs;
      logic [NTAP-1:0][6:0]   pub;
      logic [NTAP-1:0][4:0]   explen;
      logic [NTAP-1:0][4:0]   off;
      logic [NTAP-1:0][4:0]   cnt;
      logic [NTAP-1:0][4:0]   dst;
      logic [NTAP-1:0][15:0]  tm;
      logic [4:0]             pidx;
      image_t                 sp;
      image_t                 sh;
      image_t                 tx;
      logic [4:0]             tidx;
      logic                   rv;
      logic                   rb;
      logic                   rl;
      logic [15:0]            rd;
      logic                   pc;
      logic                   pr;
      logic                   sa;
   } dreg_t;

   dreg_t s_reg;
   dreg_t s_next;

   // Lowest slot at or above from that the master fills.
   function automatic logic [4:0] free_slot(input logic [15:0] mask,
                                            input logic [4:0] from);
      logic [4:0] r;
      r = 5'h10;
      for (int q = 15; q >= 0; q--) begin
         if (5'(q) >= from && !mask[q]) begin
            r = 5'(q);
         end
      end
      return r;
   endfunction

   // Byte of the empty identifier expected at position k.
   function automatic logic [7:0] id_byte(input logic [2:0] k);
      case (k)
         3'h0: return `EMPTY_ID0;
         3'h1: return `EMPTY_ID1;
         3'h2: return `EMPTY_ID2;
         3'h3: return `EMPTY_ID3;
         default: return `EMPTY_ID4;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic        mine;
      logic        act;
      logic [15:0] mask;
      logic [5:0]  slot;
      image_t      aw;
      s_next = s_reg;
      s_next.rv = 1'b0;
      s_next.rl = 1'b0;
      mine = bus.m_valid && bus.m_dst == node_addr_i;
      act = s_reg.sa;
      mask = act ? telegram_structure_config_i : 16'h0000;
      slot = 6'h00;
      aw = image_t'(act_i);
      // Status bits are forced into the actual value image.
      aw[`CW1_SLOT][`PASSIVE_BIT1] = passive_ref_done_i;
      aw[xt_sts_slot_i][`XT_CORR_BIT] = pos_corr_done_i;
      aw[xt_sts_slot_i][`XT_PASSIVE_BIT] = passive_ref_done_i;

      // Master telegrams addressed to this node.
      if (s_reg.st == D_RX && mine) begin
         s_next.widx = s_reg.widx + 5'h01;
         case (bus.m_kind)
            K_PRM: begin
               if (s_reg.widx == 5'h00) begin
                  s_next.nl = 5'h00;
                  s_next.ent = 5'h00;
                  s_next.fs = 3'h0;
               end else if (s_reg.widx == `PRM_BLK_WORD) begin
                  s_next.nl = (bus.m_data[15:5] == 11'h000) ? bus.m_data[4:0] : 5'h1F;
               end else if (s_reg.ent < 5'(NTAP)) begin
                  // Table entry fields, in order.
                  case (s_reg.fs)
                     3'h0: s_next.pub[s_reg.ent] = bus.m_data[6:0];
                     3'h1: s_next.explen[s_reg.ent] = bus.m_data[4:0];
                     3'h2: s_next.off[s_reg.ent] = bus.m_data[4:0];
                     3'h3: s_next.cnt[s_reg.ent] = bus.m_data[4:0];
                     default: s_next.dst[s_reg.ent] = bus.m_data[4:0];
                  endcase
                  s_next.fs = (s_reg.fs == 3'(`ENTRY_WORDS - 1)) ? 3'h0 : s_reg.fs + 3'h1;
                  if (s_reg.fs == 3'(`ENTRY_WORDS - 1)) begin
                     s_next.ent = s_reg.ent + 5'h01;
                  end
               end
            end
            K_CFG: begin
               if (s_reg.widx == 5'h00) begin
                  // Counts are clamped to the image size.
                  s_next.set_words = (bus.m_data[7:0] > 8'h10) ? 5'h10 : bus.m_data[4:0];
                  s_next.act_words = (bus.m_data[15:8] > 8'h10) ? 5'h10 : bus.m_data[12:8];
                  s_next.cfg_err = bus.m_data[7:0] > 8'h10 || bus.m_data[15:8] > 8'h10;
                  s_next.ids = 5'h00;
                  s_next.idb = 3'h0;
               end else if (bus.m_data[7:0] == id_byte(s_reg.idb)) begin
                  // Count complete empty identifiers.
                  s_next.idb = (s_reg.idb == `ID_LEN - 3'h1) ? 3'h0 : s_reg.idb + 3'h1;
                  if (s_reg.idb == `ID_LEN - 3'h1 && s_reg.ids != 5'h1F) begin
                     s_next.ids = s_reg.ids + 5'h01;
                  end
               end else begin
                  s_next.idb = 3'h0;
               end
            end
            default: begin
               // Master setpoints fill the slots not given to taps.
               if (s_reg.widx == 5'h00) begin
                  s_next.wptr = free_slot(mask, 5'h00);
               end
               if (s_reg.widx < s_reg.set_words && !s_next.wptr[4]) begin
                  s_next.sp[s_next.wptr[3:0]] = bus.m_data;
                  s_next.wptr = free_slot(mask, s_next.wptr + 5'h01);
               end
               if (bus.m_last && s_reg.act_words != 5'h00) begin
                  s_next.st = D_TX;
                  s_next.tidx = 5'h00;
                  s_next.tx = aw;
                  s_next.rb = bus.m_kind == K_DXB && pub_en_i;
               end
            end
         endcase
         if (bus.m_last) begin
            s_next.widx = 5'h00;
         end
      end

      // Reply words, one per cycle.
      if (s_reg.st == D_TX) begin
         s_next.rv = 1'b1;
         s_next.rd = s_reg.tx[s_reg.tidx[3:0]];
         s_next.rl = s_reg.tidx + 5'h01 == s_reg.act_words;
         s_next.tidx = s_reg.tidx + 5'h01;
         if (s_next.rl) begin
            s_next.st = D_RX;
         end
      end

      // Publisher broadcasts pass the filter table.
      if (bus.px_valid) begin
         s_next.pidx = bus.px_last ? 5'h00 : s_reg.pidx + 5'h01;
         for (int t = 0; t < NTAP; t++) begin
            slot = 6'(s_reg.dst[t]) + 6'(s_reg.pidx) - 6'(s_reg.off[t]);
            if (act && 5'(t) < s_reg.nl && s_reg.pub[t] == bus.px_src &&
                s_reg.pidx >= s_reg.off[t] &&
                6'(s_reg.pidx) < 6'(s_reg.off[t]) + 6'(s_reg.cnt[t]) &&
                slot < 6'h10) begin
               s_next.sh[slot[3:0]] = bus.px_data;
               s_next.tm[t][slot[3:0]] = 1'b1;
            end
         end
         if (bus.px_last) begin
            for (int t = 0; t < NTAP; t++) begin
               // Commit only when the length matches.
               if (act && 5'(t) < s_reg.nl && s_reg.pub[t] == bus.px_src &&
                   s_reg.pidx + 5'h01 == s_reg.explen[t]) begin
                  for (int k = 0; k < `MAX_PZD; k++) begin
                     if (s_next.tm[t][k]) begin
                        s_next.sp[k] = s_next.sh[k];
                     end
                  end
               end
               s_next.tm[t] = 16'h0000;
            end
         end
      end

      // Subscriber enable and request decode.
      s_next.sa = sub_en_i && s_next.nl != 5'h00 && s_next.ids != 5'h00;
      s_next.pc = s_next.sp[xt_ctl_slot_i][`XT_CORR_BIT];
      s_next.pr = s_next.sp[xt_ctl_slot_i][`XT_PASSIVE_BIT] ||
                  s_next.sp[`CW1_SLOT][`PASSIVE_BIT1];
   end

   // ----------------------------------------------------------------
   // Register and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // All outputs come from the state register.
   assign bus.r_valid = s_reg.rv;
   assign bus.r_bcast = s_reg.rb;
   assign bus.r_data = s_reg.rd;
   assign bus.r_last = s_reg.rl;
   assign setpoint_o = 256'(s_reg.sp);
   assign pos_corr_req_o = s_reg.pc;
   assign passive_ref_req_o = s_reg.pr;
   assign sub_active_o = s_reg.sa;
   assign cfg_err_o = s_reg.cfg_err;
endmodule

// file: rtl/master_end.sv
`timescale 1ns/1ps
`include "xt_cfg.svh"
module master_end
   import xt_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // Fieldbus.
   xt_if.master             bus,
   // AHB-Lite slave.
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT} mstate_t;
   typedef struct packed {
      mstate_t     st;
      kind_t       kind;
      logic [6:0]  dst;
      logic [4:0]  len;
      logic [4:0]  idx;
      image_t      txb;
      image_t      rxb;
      logic [4:0]  rxn;
      logic        rxb_bc;
      logic        a_we;
      logic [7:0]  a_addr;
      logic [31:0] hrd;
      logic        mv;
      logic [15:0] md;
      logic        ml;
   } mreg_t;

   mreg_t s_reg;
   mreg_t s_next;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       take;
      logic [7:0] a;
      s_next = s_reg;
      s_next.mv = 1'b0;
      s_next.ml = 1'b0;
      take = hsel_i && htrans_i[1] && hready_i;
      a = haddr_i[7:0];

      // Data phase of a write.
      if (s_reg.a_we) begin
         if (s_reg.a_addr == `A_CTRL && hwdata_i[`CTRL_GO_BIT] && s_reg.st == M_IDLE) begin
            s_next.kind = kind_t'(hwdata_i[`CTRL_KIND_LSB +: 2]);
            s_next.len = hwdata_i[`CTRL_LEN_LSB +: 5];
            s_next.dst = hwdata_i[`CTRL_DST_LSB +: 7];
            s_next.idx = 5'h00;
            s_next.st = M_SEND;
         end else if (s_reg.a_addr >= `A_TXB && s_reg.a_addr < `A_RXB) begin
            s_next.txb[s_reg.a_addr[5:2]] = hwdata_i[15:0];
         end
      end
      s_next.a_we = take && hwrite_i;
      s_next.a_addr = a;
      // Read data is prepared in the address phase.
      if (take && !hwrite_i) begin
         if (a == `A_STAT) begin
            s_next.hrd = {22'h0, s_reg.rxb_bc, s_reg.rxn, 3'h0, s_reg.st != M_IDLE};
         end else if (a >= `A_TXB && a < `A_RXB) begin
            s_next.hrd = {16'h0000, s_reg.txb[a[5:2]]};
         end else if (a >= `A_RXB && a < `A_END) begin
            s_next.hrd = {16'h0000, s_reg.rxb[a[5:2]]};
         end else begin
            s_next.hrd = 32'h0000_0000;
         end
      end

      // Telegram words, one per cycle, from the send buffer.
      case (s_reg.st)
         M_SEND: begin
            s_next.mv = 1'b1;
            s_next.md = s_reg.txb[s_reg.idx[3:0]];
            s_next.ml = s_reg.idx + 5'h01 >= s_reg.len || s_reg.idx == 5'h0F;
            s_next.idx = s_reg.idx + 5'h01;
            if (s_next.ml) begin
               s_next.rxn = 5'h00;
               s_next.rxb_bc = 1'b0;
               s_next.st = (s_reg.kind == K_DX || s_reg.kind == K_DXB) ? M_WAIT : M_IDLE;
            end
         end
         M_WAIT: begin
            // Reply or broadcast of the polled slave.
            if (bus.r_valid) begin
               if (!s_reg.rxn[4]) begin
                  s_next.rxb[s_reg.rxn[3:0]] = bus.r_data;
                  s_next.rxn = s_reg.rxn + 5'h01;
               end
               s_next.rxb_bc = bus.r_bcast;
               if (bus.r_last) begin
                  s_next.st = M_IDLE;
               end
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs from the state register; the slave never waits or errs.
   assign bus.m_valid = s_reg.mv;
   assign bus.m_kind = s_reg.kind;
   assign bus.m_dst = s_reg.dst;
   assign bus.m_data = s_reg.md;
   assign bus.m_last = s_reg.ml;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = s_reg.hrd;
endmodule

// file: tb/xt_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// Link checker
// ----------------------------------------
module xt_properties
   import xt_pkg::*;
(
   // Clock and reset.
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   // Master telegram.
   input  wire logic       m_valid,
   input  wire kind_t      m_kind,
   input  wire logic [6:0] m_dst,
   input  wire logic       m_last,
   // Drive reply.
   input  wire logic       r_valid,
   input  wire logic       r_bcast,
   input  wire logic       r_last
);
   logic [4:0] r_cnt;
   logic [4:0] m_cnt;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Word index within the running reply and the running telegram.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_cnt <= 5'h00;
         m_cnt <= 5'h00;
      end else begin
         r_cnt <= (r_valid && !r_last) ? r_cnt + 5'h01 : 5'h00;
         m_cnt <= (m_valid && !m_last) ? m_cnt + 5'h01 : 5'h00;
      end
   end

   a_reply_after_poll:
      assert property ($rose(r_valid) |-> $past(m_valid && m_last && m_kind inside {K_DX, K_DXB}, 2))
      else $error("Reply started without a poll two cycles before.");
   a_bcast_from_dxb:
      assert property ($rose(r_valid) && r_bcast |-> $past(m_kind, 2) == K_DXB)
      else $error("Broadcast reply to a plain poll.");
   a_reply_steady:
      assert property (r_valid && !r_last |=> r_valid && $stable(r_bcast))
      else $error("Reply words not consecutive or broadcast flag changed.");
   a_rlast_valid:
      assert property (r_last |-> r_valid)
      else $error("Reply end marker without a word.");
   a_reply_len:
      assert property (r_valid |-> r_cnt < 5'h10)
      else $error("Reply longer than sixteen words.");
   a_tel_steady:
      assert property (m_valid && !m_last |=> m_valid && $stable(m_kind) && $stable(m_dst))
      else $error("Telegram broken or its kind or target changed.");
   a_tel_len:
      assert property (m_valid |-> m_cnt < 5'h10)
      else $error("Telegram longer than sixteen words.");
   a_no_overlap:
      assert property (r_valid |-> !m_valid)
      else $error("Master sent while the drive replied.");
   a_mlast_valid:
      assert property (m_last |-> m_valid)
      else $error("Telegram end marker without a word.");
endmodule

// file: tb/fieldbus_cross_traffic_filter_bench.sv
`timescale 1ns/1ps
`include "xt_cfg.svh"
module fieldbus_cross_traffic_filter_bench;
   import xt_pkg::*;
   logic         core_clk_i = 1'b0;
   logic         rst_n_i = 1'b0;
   logic         hsel_i = 1'b0;
   logic [31:0]  haddr_i = 32'h0;
   logic [1:0]   htrans_i = 2'h0;
   logic         hwrite_i = 1'b0;
   logic [2:0]   hsize_i = 3'h0;
   logic [31:0]  hwdata_i = 32'h0;
   logic         hreadyout_o;
   logic         hresp_o;
   logic [31:0]  hrdata_o;
   logic         pub_en_i = 1'b1;
   logic         sub_en_i = 1'b1;
   logic         pc_i = 1'b0;
   logic         pr_i = 1'b0;
   logic [255:0] act_i = {208'h0, 16'h5A50, 16'h1111, 16'h8123};
   logic [255:0] setpoint_o;
   logic [255:0] exp_sp = 256'h0;
   logic         pc_o;
   logic         pr_o;
   logic         sub_o;
   logic         err_o;
   logic [31:0]  rd;
   logic [15:0]  tx [16];
   logic [15:0]  w0;
   logic [15:0]  w2;
   kind_t        k;
   int           n_mismatch = 0;
   int           total_checks = 0;

   xt_if bus ();

   master_end i_master_end (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus(bus.master), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o), .hrdata_o(hrdata_o));
   drive_end i_drive_end (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus(bus.drive), .node_addr_i(7'h05),
      .pub_en_i(pub_en_i), .sub_en_i(sub_en_i), .telegram_structure_config_i(16'h004C),
      .xt_ctl_slot_i(4'h4), .xt_sts_slot_i(4'h2), .act_i(act_i), .pos_corr_done_i(pc_i),
      .passive_ref_done_i(pr_i), .setpoint_o(setpoint_o), .pos_corr_req_o(pc_o),
      .passive_ref_req_o(pr_o), .sub_active_o(sub_o), .cfg_err_o(err_o));
   xt_properties i_xt_properties (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .m_valid(bus.m_valid),
      .m_kind(bus.m_kind), .m_dst(bus.m_dst), .m_last(bus.m_last), .r_valid(bus.r_valid),
      .r_bcast(bus.r_bcast), .r_last(bus.r_last));

   // Free-running core clock.
   initial begin
      forever #2 core_clk_i = ~core_clk_i;
   end

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Compares one result against its expected value.
   task automatic check(input logic [255:0] got, input logic [255:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Waits for hready high at a rising edge, with a bound.
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge core_clk_i);
      while (hreadyout_o !== 1'b1) begin
         n++;
         if (n > 50) begin
            n_mismatch++;
            end_of_test();
         end
         @(posedge core_clk_i);
      end
   endtask

   // One single-word bus transfer; read data lands in rd.
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      hsize_i <= 3'h2;
      haddr_i <= {24'h000000, a};
      wait_rdy();
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      wait_rdy();
      rd = hrdata_o;
   endtask

   // Loads n words, starts a telegram and waits until the controller is idle.
   task automatic send(input kind_t kd, input logic [6:0] dst, input logic [4:0] n);
      for (int i = 0; i < n; i++)
         ahb(1'b1, `A_TXB + 8'(4 * i), {16'h0000, tx[i]});
      ahb(1'b1, `A_CTRL, {1'b1, 8'h00, dst, 7'h00, n, 2'h0, kd});
      // Gives the busy flag one edge to appear before polling it.
      @(posedge core_clk_i);
      for (int i = 0; i < 60; i++) begin
         ahb(1'b0, `A_STAT, 32'h0);
         if (rd[0] === 1'b0) begin
            repeat (2) @(posedge core_clk_i);
            return;
         end
      end
      n_mismatch++;
      end_of_test();
   endtask

   // Filter table with two non-adjacent taps on one publisher.
   task automatic prm();
      tx = '{1: 16'h0002, 2: 16'h0021, 3: 16'h0004, 4: 16'h0001, 5: 16'h0002,
             6: 16'h0002, 7: 16'h0021, 8: 16'h0004, 9: 16'h0003, 10: 16'h0001,
             11: 16'h0006, default: 16'h0000};
      send(K_PRM, 7'h05, 5'h0C);
   endtask

   // Word counts followed by one empty identifier.
   task automatic cfg(input logic [15:0] c);
      tx = '{0: c, 1: 16'h0004, 4: 16'h00D3, 5: 16'h0040, default: 16'h0000};
      send(K_CFG, 7'h05, 5'h06);
   endtask

   // A peer broadcast of n words counting up from base.
   task automatic pub(input logic [6:0] src, input int n, input logic [15:0] base);
      for (int i = 0; i < n; i++) begin
         bus.px_valid <= 1'b1;
         bus.px_src <= src;
         bus.px_data <= base + 16'(i);
         bus.px_last <= (i == n - 1);
         @(posedge core_clk_i);
      end
      bus.px_valid <= 1'b0;
      bus.px_last <= 1'b0;
      bus.px_data <= ~bus.px_data;
      repeat (3) @(posedge core_clk_i);
   endtask

   // Main sequence.
   initial begin
      bus.px_valid = 1'b0;
      bus.px_src = 7'h00;
      bus.px_data = 16'h0000;
      bus.px_last = 1'b0;
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      check(setpoint_o, 256'h0);
      check({hreadyout_o, hresp_o, sub_o, err_o, pc_o, pr_o}, 6'h20);
      ahb(1'b0, `A_END, 32'h0);
      check(rd, 32'h0);
      prm();
      cfg(16'h0304);
      check({sub_o, err_o}, 2'h2);
      for (int i = 0; i < 4; i++) begin
         w0 = (i == 0 || i == 3) ? 16'h8000 : 16'h0000;
         w2 = (i == 0) ? 16'h0001 : ((i == 1) ? 16'h0002 : 16'h0000);
         k = (i < 2) ? K_DX : K_DXB;
         pub_en_i <= (i != 3);
         pc_i <= (i == 0);
         pr_i <= (i != 1);
         tx = '{0: w0, 1: 16'hA001, 2: w2, 3: 16'hA003, default: 16'h0000};
         send(k, 7'h05, 5'h04);
         exp_sp[31:0] = {16'hA001, w0};
         exp_sp[95:64] = {16'hA003, w2};
         check(setpoint_o, exp_sp);
         check({pc_o, pr_o}, {w2[0], w0[15] | w2[1]});
         ahb(1'b0, `A_STAT, 32'h0);
         check(rd, {22'h0, (i == 2), 9'h030});
         ahb(1'b0, `A_RXB, 32'h0);
         check(rd[15:0], {pr_i, 15'h0123});
         ahb(1'b0, `A_RXB + 8'h04, 32'h0);
         check(rd[15:0], 16'h1111);
         ahb(1'b0, `A_RXB + 8'h08, 32'h0);
         check(rd[1:0], {pr_i, pc_i});
      end
      pub(7'h21, 4, 16'hD000);
      exp_sp[63:32] = 32'hD002_D001;
      exp_sp[111:96] = 16'hD003;
      check(setpoint_o, exp_sp);
      pub(7'h22, 4, 16'hE000);
      pub(7'h21, 3, 16'hE000);
      check(setpoint_o, exp_sp);
      sub_en_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      check(sub_o, 1'b0);
      sub_en_i <= 1'b1;
      tx = '{default: 16'h0000};
      send(K_PRM, 7'h06, 5'h02);
      check(sub_o, 1'b1);
      send(K_PRM, 7'h05, 5'h02);
      check(sub_o, 1'b0);
      tx = '{0: 16'hB000, 1: 16'hB001, 2: 16'hB002, 3: 16'hB003, default: 16'h0000};
      send(K_DX, 7'h05, 5'h04);
      pub(7'h21, 4, 16'hE000);
      check(setpoint_o[63:0], 64'hB003_B002_B001_B000);
      prm();
      tx = '{0: 16'h0304, default: 16'h0000};
      send(K_CFG, 7'h05, 5'h01);
      check(sub_o, 1'b0);
      cfg(16'h0311);
      check({sub_o, err_o}, 2'h3);
      end_of_test();
   end
endmodule
